// *** design/serdes_pkg.sv ***
package serdes_pkg;
	localparam int DW = 160;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_ERRS = 8'h08;
	localparam int CTRL_RATIO_LSB = 0;
	localparam int CTRL_CODE_LSB = 3;
	localparam int CTRL_FIFO_BIT = 5;
	localparam int CTRL_TXEN_BIT = 6;
	localparam int CTRL_RXEN_BIT = 7;
	localparam int CTRL_OOB_BIT = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RESET = 9'h020;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_OOB_BIT = 1;
	localparam int STAT_CERR_BIT = 2;
	localparam int STAT_FILL_LSB = 3;
	localparam logic [1:0] SYNC66 = 2'h1;
	localparam logic [2:0] SYNC67 = 3'h2;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	localparam int CLK_MHZ = 100;
	localparam int OOB_HALF_NS = 80;
	localparam logic [3:0] OOB_HALF_CYC = 4'((OOB_HALF_NS * CLK_MHZ + 999) / 1000);
	localparam logic [2:0] OOB_MIN_EDGES = 3'h4;

	typedef enum logic [1:0] {
		CODE_NONE   = 2'b00,
		CODE_8B10B  = 2'b01,
		CODE_64B66B = 2'b10,
		CODE_64B67B = 2'b11
	} code_t;

	// Bits per word for each ratio selection
	function automatic logic [7:0] width_of(input logic [2:0] r);
		case (r)
			3'h0: width_of = 8'h10;
			3'h1: width_of = 8'h14;
			3'h2: width_of = 8'h20;
			3'h3: width_of = 8'h28;
			3'h4: width_of = 8'h40;
			3'h5: width_of = 8'h50;
			3'h6: width_of = 8'h80;
			default: width_of = 8'hA0;
		endcase
	endfunction : width_of

	// Serial bits per frame; the 64-bit codes fix their own length
	function automatic logic [7:0] frame_len(input logic [2:0] r, input code_t c);
		case (c)
			CODE_64B66B: frame_len = 8'h42;
			CODE_64B67B: frame_len = 8'h43;
			default: frame_len = width_of(r);
		endcase
	endfunction : frame_len
endpackage : serdes_pkg

// *** design/serial_transceiver_datapath.sv ***
// Function
// - Transmit serialises each word at a ratio of 16,20,32,40,64,80,128 or 160.
// - A divided word clock goes out; fabric registers transmit words on it.
// - Transmit words pass a buffer that configuration enables or bypasses.
// - Transmit optionally applies 8B/10B, 64B/66B or 64B/67B, else sends raw.
// - Receive deserialises into words of the same selectable widths.
// - Receive takes bit timing from the data; no separate clock is needed.
// - Receive reads NRZ bits and decodes the selected line code.
// - Received words are handed over on the receive user word clock.
// - All settings load at start and may change while the channel runs.
// - Low-speed out-of-band signalling is sent and detected while idle.
//
// The APB slave port and the address map were left to the implementer.
module serial_transceiver_datapath
	import serdes_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_rstn,
	input  wire logic          i_psel,
	input  wire logic          i_penable,
	input  wire logic          i_pwrite,
	input  wire logic [7:0]    i_paddr,
	input  wire logic [31:0]   i_pwdata,
	output logic      [31:0]   o_prdata,
	output logic               o_pready,
	output logic               o_pslverr,
	input  wire logic [DW-1:0] i_tx_data,
	input  wire logic          i_tx_valid,
	output logic               o_tx_ready,
	output logic               o_tx_divided_parallel_clock,
	output logic               o_tx_serial,
	input  wire logic          i_rx_serial,
	output logic               o_rx_user_word_clock,
	output logic      [DW-1:0] o_rx_data,
	output logic               o_rx_code_err
);
	typedef enum logic {TX_OFF = 1'b0, TX_RUN = 1'b1} tx_state_t;
	typedef enum logic [1:0] {RX_OFF = 2'b00, RX_HUNT = 2'b01, RX_DATA = 2'b10} rx_state_t;

	logic [1:0]        rst_sync_q;
	logic              rst_n;
	logic [CTRL_W-1:0] ctrl_q;
	logic              oob_flag_q, cerr_flag_q;
	logic [7:0]        errcnt_q;
	logic [DW-1:0]     buf_q [BUF_DEPTH];
	logic              wr_ptr_q, rd_ptr_q;
	logic [1:0]        cnt_q, cnt_d;
	logic              push, pop;
	logic [DW-1:0]     head, enc8, tx_frame, tx_shift_q;
	logic [7:0]        tx_bits_q, tx_len_q, gap_q;
	tx_state_t         tx_state_q;
	logic              tx_load;
	logic [3:0]        oob_cnt_q;
	logic              oob_lvl_q;
	logic [2:0]        rx_s_q, oob_edges_q;
	logic              rx_rise, rx_edge, rx_done, rx_err, oob_set;
	rx_state_t         rx_state_q;
	logic [7:0]        rx_cnt_q, rx_len_q;
	code_t             rx_code_q;
	logic [DW-1:0]     rx_sr_q, rx_sr_next, rx_frame, dec8, rx_word;
	logic [15:0]       sym_err;
	logic [31:0]       clr;
	logic              acc, setup_done;
	logic [7:0]        head_b0;
	logic [8:0]        pwd9;

	wire logic [2:0] ratio  = ctrl_q[CTRL_RATIO_LSB +: 3];
	wire code_t      code   = code_t'(ctrl_q[CTRL_CODE_LSB +: 2]);
	wire logic       fifo_en = ctrl_q[CTRL_FIFO_BIT];
	wire logic       tx_en  = ctrl_q[CTRL_TXEN_BIT];
	wire logic       rx_en  = ctrl_q[CTRL_RXEN_BIT];
	wire logic       oob_en = ctrl_q[CTRL_OOB_BIT];

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) rst_sync_q <= 2'h0;
		else rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// APB slave: one wait state, so every transfer answers in the second access cycle
	assign setup_done = i_psel & i_penable & ~o_pready;
	assign acc = i_psel & i_penable & o_pready;
	assign clr = (acc & i_pwrite & (i_paddr == ADDR_STAT)) ? i_pwdata : 32'h0;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup_done;
			o_prdata <= 32'h0;
			o_pslverr <= 1'b0;
			if (setup_done) begin
				case (i_paddr)
					ADDR_CTRL: o_prdata <= {23'h0, ctrl_q};
					ADDR_STAT: o_prdata <= {27'h0, cnt_q, cerr_flag_q, oob_flag_q, rx_state_q == RX_DATA};
					ADDR_ERRS: o_prdata <= {24'h0, errcnt_q};
					default: o_pslverr <= 1'b1; // Unmapped: error, reads zero
				endcase
			end
		end
	end

	// Ratio and code take effect at the next frame boundary, even mid-traffic
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) ctrl_q <= CTRL_RESET;
		else if (acc & i_pwrite & (i_paddr == ADDR_CTRL)) ctrl_q <= i_pwdata[CTRL_W-1:0];
	end

	// Sticky flags; a new event in the clearing cycle wins
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			oob_flag_q  <= 1'b0;
			cerr_flag_q <= 1'b0;
			errcnt_q    <= 8'h0;
		end else begin
			oob_flag_q  <= oob_set | (oob_flag_q & ~clr[STAT_OOB_BIT]);
			cerr_flag_q <= (rx_done & rx_err) | (cerr_flag_q & ~clr[STAT_CERR_BIT]);
			if (rx_done & rx_err & (errcnt_q != 8'hFF)) errcnt_q <= errcnt_q + 8'h1; // Saturates
		end
	end

	// Two-entry transmit buffer; bypass keeps only one word in flight
	assign push = i_tx_valid & o_tx_ready;
	assign pop  = tx_load & (cnt_q != 2'h0);
	assign cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q      <= 2'h0;
			wr_ptr_q   <= 1'b0;
			rd_ptr_q   <= 1'b0;
			o_tx_ready <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			wr_ptr_q   <= wr_ptr_q ^ push;
			rd_ptr_q   <= rd_ptr_q ^ pop;
			o_tx_ready <= fifo_en ? (cnt_d < BUF_DEPTH) : (cnt_d == 2'h0);
		end
	end

	// Buffer storage needs no reset; entries are read only when counted
	always_ff @(posedge i_clk) begin
		if (push) buf_q[wr_ptr_q] <= i_tx_data;
	end
	assign head = (cnt_q != 2'h0) ? buf_q[rd_ptr_q] : '0;
	assign head_b0 = head[7:0];
	assign pwd9 = i_pwdata[8:0];

	// Per-symbol 8B/10B mapping: two guard bits force a transition in each symbol
	for (genvar g = 0; g < 16; g++) begin : g_sym
		assign enc8[10*g +: 10] = {head[8*g+7], ~head[8*g+7], head[8*g +: 8]};
		assign dec8[8*g +: 8]   = rx_frame[10*g +: 8];
		assign sym_err[g] = (8'(10*g) < rx_len_q) & ((rx_frame[10*g+9] != rx_frame[10*g+7]) |
			(rx_frame[10*g+8] == rx_frame[10*g+7]));
	end
	assign dec8[DW-1:128] = '0;

	// Line code selection; an empty buffer sends a zero fill word
	always_comb begin
		case (code)
			CODE_8B10B:  tx_frame = enc8;
			CODE_64B66B: tx_frame = {94'h0, head[63:0], SYNC66};
			CODE_64B67B: tx_frame = {93'h0, head[63:0], SYNC67};
			default:     tx_frame = head;
		endcase
	end

	// Serialiser: one preamble bit, then back-to-back frames LSB first
	assign tx_load = tx_en & ((tx_state_q == TX_OFF) | (tx_bits_q == 8'h01));
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= TX_OFF;
			tx_shift_q <= '0;
			tx_bits_q  <= 8'h0;
			tx_len_q   <= 8'h0;
			o_tx_serial <= 1'b0;
			o_tx_divided_parallel_clock <= 1'b0;
		end else begin
			o_tx_divided_parallel_clock <= tx_load;
			case (tx_state_q)
				TX_OFF: o_tx_serial <= tx_en ? 1'b1 : (oob_en & oob_lvl_q);
				TX_RUN: o_tx_serial <= tx_shift_q[0];
				default: o_tx_serial <= 1'b0;
			endcase
			if (tx_load) begin
				tx_state_q <= TX_RUN;
				tx_shift_q <= tx_frame;
				tx_bits_q  <= frame_len(ratio, code);
				tx_len_q   <= frame_len(ratio, code);
			end else if (tx_state_q == TX_RUN) begin
				tx_shift_q <= tx_shift_q >> 1;
				tx_bits_q  <= tx_bits_q - 8'h1;
				if (tx_bits_q == 8'h01) tx_state_q <= TX_OFF;
			end
		end
	end

	// Out-of-band tone: slow square wave while high-speed sending is off
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			oob_cnt_q <= 4'h0;
			oob_lvl_q <= 1'b0;
		end else if (!oob_en || tx_en) begin
			oob_cnt_q <= 4'h0;
			oob_lvl_q <= 1'b0;
		end else if (oob_cnt_q == OOB_HALF_CYC - 4'h1) begin
			oob_cnt_q <= 4'h0;
			oob_lvl_q <= ~oob_lvl_q;
		end else begin
			oob_cnt_q <= oob_cnt_q + 4'h1;
		end
	end

	// Line input synchroniser; only stage two and three feed logic
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) rx_s_q <= 3'h0;
		else rx_s_q <= {rx_s_q[1:0], i_rx_serial};
	end
	assign rx_rise = rx_s_q[1] & ~rx_s_q[2];
	assign rx_edge = rx_s_q[1] ^ rx_s_q[2];

	// Framing and decode; bit timing comes only from the data edge
	assign rx_sr_next = {rx_s_q[1], rx_sr_q[DW-1:1]};
	assign rx_frame   = rx_sr_next >> (8'(DW) - rx_len_q);
	assign rx_done    = (rx_state_q == RX_DATA) & (rx_cnt_q == rx_len_q - 8'h1);
	always_comb begin
		case (rx_code_q)
			CODE_8B10B: begin
				rx_word = dec8;
				rx_err  = |sym_err;
			end
			CODE_64B66B: begin
				rx_word = {96'h0, rx_frame[65:2]};
				rx_err  = rx_frame[1:0] != SYNC66;
			end
			CODE_64B67B: begin
				rx_word = {96'h0, rx_frame[66:3]};
				rx_err  = rx_frame[2:0] != SYNC67;
			end
			default: begin
				rx_word = rx_frame;
				rx_err  = 1'b0;
			end
		endcase
	end

	// Receive state: hunt for the preamble edge, then count whole frames
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_q <= RX_OFF;
			rx_cnt_q   <= 8'h0;
			rx_len_q   <= 8'h10;
			rx_code_q  <= CODE_NONE;
			rx_sr_q    <= '0;
		end else if (!rx_en) begin
			rx_state_q <= RX_OFF;
		end else begin
			case (rx_state_q)
				RX_OFF: rx_state_q <= RX_HUNT;
				RX_HUNT: begin
					if (rx_rise) begin
						rx_state_q <= RX_DATA;
						rx_cnt_q   <= 8'h0;
						rx_len_q   <= frame_len(ratio, code);
						rx_code_q  <= code;
					end
				end
				RX_DATA: begin
					rx_sr_q  <= rx_sr_next;
					rx_cnt_q <= rx_done ? 8'h0 : rx_cnt_q + 8'h1;
					if (rx_done) begin
						rx_len_q  <= frame_len(ratio, code);
						rx_code_q <= code;
					end
				end
				default: rx_state_q <= RX_OFF;
			endcase
		end
	end

	// Word handover: data and its one-cycle strobe leave from flops together
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rx_user_word_clock <= 1'b0;
			o_rx_data     <= '0;
			o_rx_code_err <= 1'b0;
		end else begin
			o_rx_user_word_clock <= rx_done;
			o_rx_code_err <= rx_done & rx_err;
			if (rx_done) o_rx_data <= rx_word;
		end
	end

	// Out-of-band detector: counts edges while the receiver is off
	assign oob_set = (rx_state_q == RX_OFF) & rx_edge & (oob_edges_q == OOB_MIN_EDGES - 3'h1);
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) oob_edges_q <= 3'h0;
		else if (rx_state_q != RX_OFF) oob_edges_q <= 3'h0;
		else if (rx_edge && oob_edges_q != OOB_MIN_EDGES) oob_edges_q <= oob_edges_q + 3'h1;
	end

	// Helper for checks: cycles since the last word load
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) gap_q <= 8'h0;
		else if (tx_load) gap_q <= 8'h1;
		else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h1;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	sequence s_lock16;
		(rx_state_q == RX_HUNT) && rx_rise && rx_en && (frame_len(ratio, code) == 8'h10);
	endsequence
	sequence s_oob_idle;
		(tx_state_q == TX_OFF && !tx_en && oob_en) [*2];
	endsequence

	a_tx_word_gap: assert property ((tx_load && tx_state_q == TX_RUN) |-> gap_q == tx_len_q)
		else $error("transmit word clock spacing differs from frame length");
	a_tx_buf_ready: assert property ((cnt_q == 2'h2 || (!fifo_en && cnt_q != 2'h0)) |-> !o_tx_ready)
		else $error("transmit buffer ready while it cannot accept");
	a_tx_enc_8b10b: assert property ((tx_load && code == CODE_8B10B) |=>
		tx_shift_q[9:0] == {$past(head_b0[7]), ~$past(head_b0[7]), $past(head_b0)})
		else $error("8b10b symbol wrong");
	a_tx_sync_66: assert property ((tx_load && code == CODE_64B66B) |=> tx_shift_q[1:0] == SYNC66)
		else $error("64b66b header missing");
	a_rx_first_word: assert property (s_lock16 |-> ##17 (o_rx_user_word_clock || rx_state_q == RX_OFF))
		else $error("16-bit word not delivered on time");
	a_rx_lock_edge: assert property ($rose(rx_state_q == RX_DATA) |-> $past(rx_rise))
		else $error("receiver locked without a data edge");
	a_rx_err_flag: assert property ((rx_done && rx_err) |=> cerr_flag_q && o_rx_code_err)
		else $error("decode error not flagged");
	a_cfg_live: assert property ((acc && i_pwrite && i_paddr == ADDR_CTRL) |=> ctrl_q == $past(pwd9))
		else $error("control write not applied");
	a_oob_tone: assert property (s_oob_idle |-> ##[1:9] ($changed(o_tx_serial) || !oob_en || tx_en))
		else $error("out-of-band tone stalled");
	a_oob_detect: assert property (oob_set |=> oob_flag_q)
		else $error("out-of-band activity not flagged");
endmodule : serial_transceiver_datapath

// *** test/remote_serial_peer.sv ***
// Far transceiver; drives the serial line into the block, low while idle
module remote_serial_peer (
	input  wire logic i_clk,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_line = 1'b0;

	// Start bit, then NRZ frame bits LSB first; our own timing rides in the data
	task automatic send(input logic [511:0] b, input int n);
		@(posedge i_clk);
		o_line <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_line <= b[i];
		end
		@(posedge i_clk);
		o_line <= 1'b0;
	endtask : send

	// Slow square wave while the fast path is idle
	task automatic tone(input int edges);
		repeat (edges) begin
			repeat (8) @(posedge i_clk);
			o_line <= ~o_line;
		end
	endtask : tone
endmodule : remote_serial_peer

// *** test/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import serdes_pkg::*;

	logic          i_clk, i_rstn, psel, penable, pwrite, tx_valid;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, rdv;
	logic          pready, pslverr, erv, tx_ready, tx_wclk, tx_ser, rx_ser, rx_wclk, rx_err;
	logic [DW-1:0] tx_data, rx_data;
	logic [31:0]   seed = 32'h0000783C;
	int            n_mismatch, samples_checked;
	int            wt[8] = '{16, 20, 32, 40, 64, 80, 128, 160};

	serial_transceiver_datapath serial_transceiver_datapath_i (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_tx_divided_parallel_clock(tx_wclk),
		.o_tx_serial(tx_ser), .i_rx_serial(rx_ser), .o_rx_user_word_clock(rx_wclk),
		.o_rx_data(rx_data), .o_rx_code_err(rx_err));
	remote_serial_peer remote_serial_peer_i (.i_clk(i_clk), .o_line(rx_ser));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [DW-1:0] rw();
		return {rnd(), rnd(), rnd(), rnd(), rnd()};
	endfunction : rw

	// Line bits of one frame, LSB first; returns the frame length
	function automatic int enc(input logic [DW-1:0] d, input int sel, input int code, output logic [255:0] b);
		b = '0;
		case (code)
			0: for (int i = 0; i < wt[sel]; i++) b[i] = d[i];
			1: for (int k = 0; k < wt[sel] / 10; k++) b[10*k +: 10] = {d[8*k+7], ~d[8*k+7], d[8*k +: 8]};
			2: b[65:0] = {d[63:0], 2'b01};
			default: b[66:0] = {d[63:0], 3'b010};
		endcase
		return code == 2 ? 66 : code == 3 ? 67 : wt[sel];
	endfunction : enc

	// Word the receiver should hand over after decoding
	function automatic logic [DW-1:0] dec(input logic [DW-1:0] d, input int sel, input int code);
		int n;
		n = code >= 2 ? 64 : code == 1 ? 8 * (wt[sel] / 10) : wt[sel];
		dec = '0;
		for (int i = 0; i < n; i++) dec[i] = d[i];
	endfunction : dec

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// A hang counts against the run and ends it at once
	task automatic fail_out();
		n_mismatch++;
		tally_and_finish();
	endtask : fail_out

	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; the wait is the slave's, only bounded here
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd);
		int t;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		t = 0;
		// Sampled right at the edge, before the slave's flops update, so the answer is taken where it counts
		do begin
			@(posedge i_clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (pready !== 1'b1) fail_out();
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Offers one word for up to n cycles; ok tells whether it was taken
	task automatic push(input logic [DW-1:0] d, input int n, output bit ok);
		@(posedge i_clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		ok = 0;
		repeat (n) begin
			@(negedge i_clk);
			if (tx_ready === 1'b1) begin
				ok = 1;
				break;
			end
		end
		@(posedge i_clk);
		tx_valid <= 1'b0;
	endtask : push

	// Collects the n line bits that follow a word clock pulse; the pulse cycle itself
	// still shows the preamble or the last bit of the frame before
	task automatic get_tx(input int n, output logic [255:0] b);
		int t;
		b = '0;
		t = 0;
		// A pulse already standing counts: back-to-back frames pulse during the last bit
		while (tx_wclk !== 1'b1 && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		if (tx_wclk !== 1'b1) fail_out();
		for (int i = 0; i < n; i++) begin
			@(negedge i_clk);
			b[i] = tx_ser;
		end
	endtask : get_tx

	task automatic rx_word(input logic [DW-1:0] d, input bit err);
		int t;
		t = 0;
		do begin
			@(negedge i_clk);
			t++;
		end while (rx_wclk !== 1'b1 && t < 400);
		if (rx_wclk !== 1'b1) fail_out();
		if (!err) chk(rx_data, d);
		chk(rx_err, err);
	endtask : rx_word

	// Cycles the line holds level v, bounded
	task automatic run_len(input logic v, output int n);
		n = 0;
		while (tx_ser === v && n < 40) begin
			@(negedge i_clk);
			n++;
		end
	endtask : run_len

	// Main sequence
	initial begin
		logic [DW-1:0] w[2];
		logic [255:0]  e, g;
		logic [511:0]  two;
		int            sel, code, n, nacc, it;
		bit            ok;
		{psel, penable, pwrite, tx_valid, i_rstn} = '0;
		paddr = '0;
		pwdata = '0;
		tx_data = '0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk);
		apb(0, ADDR_CTRL, 0);
		chk(rdv, 32'(CTRL_RESET));
		apb(1, 8'h0C, 32'hFFFFFFFF);
		chk(erv, 1'b1);
		$display("test registers done");
		// Fill until refused, then drain; bypass keeps one word only
		for (code = 0; code < 4; code++) begin
			sel = code == 1 ? 2 * (rnd() % 4) + 1 : rnd() % 8;
			nacc = code == 3 ? 1 : 2;
			apb(1, ADDR_CTRL, (code == 3 ? 0 : 32'h020) | code << 3 | sel);
			repeat (170) @(posedge i_clk);
			w[0] = rw();
			w[1] = rw();
			push(w[0], 4, ok);
			push(w[1], 4, ok);
			chk(ok, nacc == 2);
			push(rw(), 4, ok);
			chk(ok, 1'b0);
			apb(0, ADDR_STAT, 0);
			chk(rdv[4:3], nacc);
			apb(1, ADDR_CTRL, (code == 3 ? 32'h040 : 32'h060) | code << 3 | sel);
			for (int k = 0; k < nacc; k++) begin
				n = enc(w[k], sel, code, e);
				get_tx(n, g);
				chk(g, e);
			end
			apb(1, ADDR_CTRL, 32'h020);
		end
		$display("test transmit done");
		// Two back-to-back frames; the second 8B/10B one has a broken guard bit
		// A fifth pass pins a raw 16-bit word so the first-word timing is always exercised
		for (it = 0; it < 5; it++) begin
			code = it % 4;
			sel = it == 4 ? 0 : code == 1 ? 2 * (rnd() % 4) + 1 : rnd() % 8;
			apb(1, ADDR_CTRL, 32'h0A0 | code << 3 | sel);
			w[0] = rw();
			w[1] = rw();
			n = enc(w[0], sel, code, e);
			void'(enc(w[1], sel, code, g));
			if (code == 1) g[8] = ~g[8];
			two = {256'h0, e} | ({256'h0, g} << n);
			fork
				remote_serial_peer_i.send(two, 2 * n);
				begin
					rx_word(dec(w[0], sel, code), 1'b0);
					rx_word(dec(w[1], sel, code), code == 1);
				end
			join
			apb(1, ADDR_CTRL, 32'h020);
		end
		$display("test receive done");
		apb(1, ADDR_CTRL, 32'h120);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, n);
		chk(n, 8);
		run_len(1'b0, n);
		chk(n, 8);
		remote_serial_peer_i.tone(6);
		apb(0, ADDR_STAT, 0);
		chk(rdv[2:1], 2'b11);
		apb(1, ADDR_STAT, 32'h6);
		apb(0, ADDR_STAT, 0);
		chk(rdv[2:1], 2'b00);
		$display("test out of band done");
		tally_and_finish();
	end
endmodule : tb
